// *** opd_params.svh ***
// Offsets, field positions and fixed values of the operand decoder
`ifndef OPD_PARAMS_SVH
`define OPD_PARAMS_SVH
`define OPD_A_CTRL   6'h00
`define OPD_A_STAT   6'h04
`define OPD_A_FLAG   6'h08
`define OPD_A_OPND   6'h0c
`define OPD_A_RES    6'h10
`define OPD_A_XY     6'h14
`define OPD_A_SPPC   6'h18
`define OPD_A_ACC    6'h1c
`define OPD_A_EA     6'h20
`define OPD_A_PRIO   6'h24
`define OPD_A_VEC    6'h28
`define OPD_C_DEC    0
`define OPD_C_ALU    1
`define OPD_C_SUB    2
`define OPD_C_WIDE   3
`define OPD_C_MODE   6:4
`define OPD_F_C      0
`define OPD_F_V      1
`define OPD_F_Z      2
`define OPD_F_N      3
`define OPD_F_I      4
`define OPD_F_X      6
`define OPD_FLAG_RST 8'h50
`define OPD_PFX      8'h18
`define OPD_VEC_TOP  16'hfffe
`define OPD_VEC_IRQ  16'hfff2
`define OPD_VEC_WIN  9'h1ff
`define OPD_NNM      6
`define OPD_NIRQ     8
`define OPD_SRC_POR  5'h00
`define OPD_SRC_TRAP 5'h03
`define OPD_SRC_SWI  5'h04
`define OPD_SRC_NMI  5'h05
`endif

// *** opd_pkg.sv ***
// Types shared by the operand decoder
package opd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_OPC  = 4'h1,
    ST_PB   = 4'h2,
    ST_EXT  = 4'h3,
    ST_PTR  = 4'h4,
    ST_VEC  = 4'h5
  } opd_state_e;
  typedef enum logic [2:0] {
    M_IMPLICIT_OPERAND     = 3'h0,
    M_LITERAL_OPERAND      = 3'h1,
    M_DIRECT_PAGE          = 3'h2,
    M_FULL_ADDRESS_OPERAND = 3'h3,
    M_REL8                 = 3'h4,
    M_REL16                = 3'h5,
    M_INDEXED              = 3'h6
  } opd_mode_e;
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } opd_mreq_s;
  typedef struct packed {
    logic [7:0] data;
    logic       ack;
  } opd_mrsp_s;
endpackage

// *** opd_core.sv ***
// Operand decoder, condition flags and exception ordering with Avalon-MM registers
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "opd_params.svh"

// What this block does
// [RQ1] Sign flag set when the result is negative, cleared otherwise.
// [RQ2] Zero flag set when all result bits are zero, cleared otherwise.
// [RQ3] Overflow flag set on two's complement overflow, cleared otherwise.
// [RQ4] Carry flag set on add carry out or subtract borrow, cleared otherwise.
// [RQ5] A word is two bytes, high byte at the lower address.
// [RQ6] Instructions and operands may start at any byte address, no fault.
// [RQ7] Direct page address is one byte low, high byte zero.
// [RQ8] Relative target is current pc plus signed 8 or 16 bit offset.
// [RQ9] Short indexed form adds a signed 5 bit offset, -16 to +15.
// [RQ10] Base field picks X, Y, stack pointer or pc for 00 to 11.
// [RQ11] Constant form: 9 bit with sign in bit 0, 16 bit, or indirect.
// [RQ12] One extension byte for 9 bit offsets, two for 16 bit.
// [RQ13] Auto form adjusts X, Y or SP by 1 to 8, before or after.
// [RQ14] Accumulator form adds A, B or D unsigned; code 11 is D indirect.
// [RQ15] Indirect forms read a 16 bit pointer that becomes the address.
// [RQ16] Opcode byte 18 hex prefixes a second page opcode.
// [RQ17] Handler addresses come from vectors in the top 128 bytes.
// [RQ18] Top six vectors serve resets and non-maskable sources.
// [RQ19] Simultaneous requests are served in fixed priority order.
// [RQ20] Order: reset, clock monitor, watchdog, trap, soft trap, nmi pin.
// [RQ21] Nmi pin taken only while its mask flag is clear.
// [RQ22] Any one maskable source may be promoted above the others.
// [RQ23] Maskable requests need the global mask clear; it resets to one.
// [RQ24] Promotion writes only while the global mask is set.
// [RQ25] Vectors are read high byte first from the lower address.
module opd_core (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Avalon-MM register slave
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  // Program and data memory
  output opd_pkg::opd_mreq_s     mem_req,
  input  wire opd_pkg::opd_mrsp_s mem_rsp,
  // Exception requests
  input  wire logic              clkmon_reset,
  input  wire logic              watchdog_reset,
  input  wire logic              unimpl_trap,
  input  wire logic              soft_trap_instr,
  input  wire logic              pin_level_nmi_request,
  input  wire logic [7:0]        irq_req
);
  import opd_pkg::*;

  opd_state_e  state_q, state_d;
  opd_mode_e   mode_q, mode_d;
  logic        ack_q, ack_d, cnt_q, cnt_d, page2_q, page2_d, por_q, por_d;
  logic [31:0] rd_q, rd_d;
  logic [7:0]  flags_q, flags_d, prio_q, prio_d, opc_q, opc_d, pb_q, pb_d;
  logic [15:0] opa_q, opa_d, opb_q, opb_d, res_q, res_d, d_q, d_d;
  logic [15:0] x_q, x_d, y_q, y_d, sp_q, sp_d, pc_q, pc_d;
  logic [15:0] ext_q, ext_d, ea_q, ea_d, addr_q, addr_d, hnd_q, hnd_d;
  logic [15:0] vaddr_q, vaddr_d;
  logic [4:0]  src_q, src_d, sel;
  logic [5:0]  nm;
  logic [7:0]  mk, pbv;
  logic [15:0] vec, vtmp, pc_n, ext_n, idx, adj, nxt, base_v;
  logic [16:0] s16;
  logic [8:0]  s8;
  logic [1:0]  rr_v;
  logic        wr_go, alu_go, dec_go, take, fin, ind, a_s, b_s, r_s, alu_sub, alu_wide;

  function automatic logic [31:0] opd_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++) o[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
    return o;
  endfunction

  function automatic logic [15:0] opd_irq_vec(input int k);
    return `OPD_VEC_IRQ - 16'(2 * k);
  endfunction

  // Base register select
  function automatic logic [15:0] opd_base(input logic [1:0] rr, input logic [15:0] x,
                                           input logic [15:0] y, input logic [15:0] s,
                                           input logic [15:0] p);
    case (rr)
      2'h0:    return x;
      2'h1:    return y;
      2'h2:    return s;
      default: return p;
    endcase
  endfunction

  // Extension bytes that follow a postbyte
  function automatic logic [1:0] opd_xb_len(input logic [7:0] pb);
    if (pb[7:5] == 3'h7 && !pb[2]) return pb[1] ? 2'h2 : 2'h1; // [RQ12]
    return 2'h0;
  endfunction

  // Register slave: one wait cycle, answer on the second
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_go       = write & ack_q;
  assign readdata    = rd_q;
  assign alu_sub     = writedata[`OPD_C_SUB];
  assign alu_wide    = writedata[`OPD_C_WIDE];
  assign alu_go      = wr_go && address == `OPD_A_CTRL && writedata[`OPD_C_ALU];
  assign dec_go      = wr_go && address == `OPD_A_CTRL && writedata[`OPD_C_DEC];
  assign mem_req.rd   = state_q != ST_IDLE;
  assign mem_req.addr = addr_q;

  always_comb begin
    ack_d = (read | write) & ~ack_q;
    rd_d  = rd_q;
    if (read && !ack_q) begin
      case (address)
        `OPD_A_CTRL: rd_d = {25'h0000000, mode_q, 4'h0};
        `OPD_A_STAT: rd_d = {19'h00000, src_q, 3'h0, page2_q, state_q};
        `OPD_A_FLAG: rd_d = {24'h000000, flags_q};
        `OPD_A_OPND: rd_d = {opb_q, opa_q};
        `OPD_A_RES:  rd_d = {16'h0000, res_q};
        `OPD_A_XY:   rd_d = {y_q, x_q};
        `OPD_A_SPPC: rd_d = {pc_q, sp_q};
        `OPD_A_ACC:  rd_d = {16'h0000, d_q};
        `OPD_A_EA:   rd_d = {pb_q, opc_q, ea_q};
        `OPD_A_PRIO: rd_d = {24'h000000, prio_q};
        `OPD_A_VEC:  rd_d = {vaddr_q, hnd_q};
        default:     rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rd_q  <= rd_d;
    end
  end

  // Exception arbitration
  always_comb begin
    nm   = {pin_level_nmi_request & ~flags_q[`OPD_F_X], soft_trap_instr, unimpl_trap,
            watchdog_reset, clkmon_reset, por_q}; // [RQ20] [RQ21]
    mk   = irq_req & {`OPD_NIRQ{~flags_q[`OPD_F_I]}}; // [RQ23]
    sel  = 5'h00;
    vtmp = 16'h0000;
    for (int k = `OPD_NIRQ - 1; k >= 0; k--) begin
      if (mk[k]) sel = 5'(`OPD_NNM + k); // [RQ19]
    end
    for (int k = 0; k < `OPD_NIRQ; k++) begin
      vtmp = opd_irq_vec(k);
      if (mk[k] && prio_q == vtmp[7:0]) sel = 5'(`OPD_NNM + k); // [RQ22]
    end
    for (int i = `OPD_NNM - 1; i >= 0; i--) begin
      if (nm[i]) sel = 5'(i); // [RQ19] [RQ20]
    end
    take = (|nm) | (|mk);
    if (sel < 5'(`OPD_NNM)) vec = `OPD_VEC_TOP - {10'h000, sel, 1'b0}; // [RQ18]
    else vec = opd_irq_vec(int'(sel) - `OPD_NNM); // [RQ18]
  end

  // Flags, registers and the fetch sequencer
  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    cnt_d   = cnt_q;
    page2_d = page2_q;
    por_d   = por_q;
    flags_d = flags_q;
    prio_d  = prio_q;
    opc_d   = opc_q;
    pb_d    = pb_q;
    opa_d   = opa_q;
    opb_d   = opb_q;
    res_d   = res_q;
    d_d     = d_q;
    x_d     = x_q;
    y_d     = y_q;
    sp_d    = sp_q;
    pc_d    = pc_q;
    ext_d   = ext_q;
    ea_d    = ea_q;
    addr_d  = addr_q;
    hnd_d   = hnd_q;
    vaddr_d = vaddr_q;
    src_d   = src_q;
    fin     = 1'b0;
    ind     = 1'b0;
    idx     = 16'h0000;
    adj     = 16'h0000;
    nxt     = 16'h0000;
    pc_n    = addr_q + 16'h0001; // [RQ6]
    ext_n   = {ext_q[7:0], mem_rsp.data}; // [RQ5]
    pbv     = (state_q == ST_PB) ? mem_rsp.data : pb_q;
    rr_v    = (pbv[7:5] == 3'h7) ? pbv[4:3] : pbv[7:6]; // [RQ10]
    base_v  = opd_base(rr_v, x_q, y_q, sp_q, pc_n); // [RQ10]
    s16     = alu_sub ? {1'b0, opa_q} - {1'b0, opb_q} : {1'b0, opa_q} + {1'b0, opb_q};
    s8      = alu_sub ? {1'b0, opa_q[7:0]} - {1'b0, opb_q[7:0]}
                      : {1'b0, opa_q[7:0]} + {1'b0, opb_q[7:0]};
    a_s     = alu_wide ? opa_q[15] : opa_q[7];
    b_s     = alu_wide ? opb_q[15] : opb_q[7];
    r_s     = alu_wide ? s16[15] : s8[7];

    if (wr_go) begin
      case (address)
        `OPD_A_CTRL: mode_d = opd_mode_e'(writedata[`OPD_C_MODE]);
        `OPD_A_FLAG: if (byteenable[0]) flags_d = writedata[7:0]; // [RQ23]
        `OPD_A_OPND: {opb_d, opa_d} = opd_merge({opb_q, opa_q}, writedata, byteenable);
        `OPD_A_XY:   {y_d, x_d} = opd_merge({y_q, x_q}, writedata, byteenable);
        `OPD_A_SPPC: {pc_d, sp_d} = opd_merge({pc_q, sp_q}, writedata, byteenable);
        `OPD_A_ACC: begin
          d_d[15:8] = byteenable[1] ? writedata[15:8] : d_q[15:8];
          d_d[7:0]  = byteenable[0] ? writedata[7:0] : d_q[7:0];
        end
        `OPD_A_PRIO: if (byteenable[0] && flags_q[`OPD_F_I]) prio_d = writedata[7:0]; // [RQ24]
        default: ;
      endcase
    end

    if (alu_go) begin
      res_d            = alu_wide ? s16[15:0] : {8'h00, s8[7:0]};
      flags_d[`OPD_F_N] = r_s; // [RQ1]
      flags_d[`OPD_F_Z] = alu_wide ? (s16[15:0] == 16'h0000) : (s8[7:0] == 8'h00); // [RQ2]
      flags_d[`OPD_F_V] = (alu_sub ? (a_s ^ b_s) : ~(a_s ^ b_s)) & (r_s ^ a_s); // [RQ3]
      flags_d[`OPD_F_C] = alu_wide ? s16[16] : s8[8]; // [RQ4]
    end

    case (state_q)
      ST_IDLE: begin
        if (take) begin
          addr_d  = vec; // [RQ17]
          vaddr_d = vec;
          src_d   = sel;
          cnt_d   = 1'b1;
          state_d = ST_VEC;
          flags_d[`OPD_F_I] = 1'b1;
          if (sel < 5'(`OPD_NNM) && sel != `OPD_SRC_TRAP && sel != `OPD_SRC_SWI)
            flags_d[`OPD_F_X] = 1'b1;
          if (sel == `OPD_SRC_POR) por_d = 1'b0;
        end else if (dec_go) begin
          addr_d  = pc_q;
          page2_d = 1'b0;
          state_d = ST_OPC;
        end
      end
      ST_OPC: begin
        if (mem_rsp.ack) begin
          addr_d = pc_n;
          pc_d   = pc_n;
          if (mem_rsp.data == `OPD_PFX && !page2_q) begin
            page2_d = 1'b1; // [RQ16]
          end else begin
            opc_d = mem_rsp.data; // [RQ16]
            ext_d = 16'h0000;
            cnt_d = 1'b0;
            case (mode_q)
              M_DIRECT_PAGE, M_REL8:          state_d = ST_EXT;
              M_FULL_ADDRESS_OPERAND, M_REL16: begin
                cnt_d   = 1'b1;
                state_d = ST_EXT;
              end
              M_INDEXED: state_d = ST_PB;
              default: begin
                ea_d    = pc_n;
                state_d = ST_IDLE;
              end
            endcase
          end
        end
      end
      ST_PB: begin
        if (mem_rsp.ack) begin
          addr_d = pc_n;
          pc_d   = pc_n;
          pb_d   = mem_rsp.data;
          if (opd_xb_len(mem_rsp.data) == 2'h0) begin
            fin = 1'b1;
          end else begin
            cnt_d   = opd_xb_len(mem_rsp.data) == 2'h2; // [RQ12]
            state_d = ST_EXT;
          end
        end
      end
      ST_EXT: begin
        if (mem_rsp.ack) begin
          ext_d  = ext_n;
          addr_d = pc_n;
          pc_d   = pc_n;
          cnt_d  = 1'b0;
          fin    = !cnt_q;
        end
      end
      ST_PTR, ST_VEC: begin
        if (mem_rsp.ack) begin
          ext_d  = ext_n;
          addr_d = pc_n; // [RQ25]
          cnt_d  = 1'b0;
          if (!cnt_q) begin
            state_d = ST_IDLE;
            if (state_q == ST_PTR) begin
              ea_d = ext_n; // [RQ15]
            end else begin
              hnd_d = ext_n; // [RQ25]
              pc_d  = ext_n;
            end
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase

    if (fin) begin
      state_d = ST_IDLE;
      case (mode_q)
        M_DIRECT_PAGE:          ea_d = {8'h00, ext_n[7:0]}; // [RQ7]
        M_FULL_ADDRESS_OPERAND: ea_d = ext_n;
        M_REL8:                 ea_d = pc_n + {{8{ext_n[7]}}, ext_n[7:0]}; // [RQ8]
        M_REL16:                ea_d = pc_n + ext_n; // [RQ8]
        default: begin
          if (!pbv[5]) begin
            idx = base_v + {{11{pbv[4]}}, pbv[4:0]}; // [RQ9]
          end else if (pbv[7:6] != 2'h3) begin
            adj = pbv[3] ? {12'hfff, pbv[3:0]} : {12'h000, pbv[3:0]} + 16'h0001; // [RQ13]
            nxt = base_v + adj;
            idx = pbv[4] ? base_v : nxt; // [RQ13]
            case (pbv[7:6])
              2'h0:    x_d  = nxt;
              2'h1:    y_d  = nxt;
              default: sp_d = nxt;
            endcase
          end else if (!pbv[2]) begin
            idx = base_v + (pbv[1] ? ext_n : {{8{pbv[0]}}, ext_n[7:0]}); // [RQ11]
            ind = &pbv[1:0]; // [RQ11]
          end else begin
            idx = base_v + (pbv[1] ? d_q : {8'h00, pbv[0] ? d_q[7:0] : d_q[15:8]}); // [RQ14]
            ind = &pbv[1:0]; // [RQ14]
          end
          ea_d = idx;
          if (ind) begin
            addr_d  = idx; // [RQ15]
            cnt_d   = 1'b1;
            state_d = ST_PTR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      mode_q  <= M_IMPLICIT_OPERAND;
      cnt_q   <= 1'b0;
      page2_q <= 1'b0;
      por_q   <= 1'b1;
      flags_q <= `OPD_FLAG_RST; // [RQ23]
      prio_q  <= 8'h00;
      opc_q   <= 8'h00;
      pb_q    <= 8'h00;
      opa_q   <= 16'h0000;
      opb_q   <= 16'h0000;
      res_q   <= 16'h0000;
      d_q     <= 16'h0000;
      x_q     <= 16'h0000;
      y_q     <= 16'h0000;
      sp_q    <= 16'h0000;
      pc_q    <= 16'h0000;
      ext_q   <= 16'h0000;
      ea_q    <= 16'h0000;
      addr_q  <= 16'h0000;
      hnd_q   <= 16'h0000;
      vaddr_q <= 16'h0000;
      src_q   <= 5'h00;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      cnt_q   <= cnt_d;
      page2_q <= page2_d;
      por_q   <= por_d;
      flags_q <= flags_d;
      prio_q  <= prio_d;
      opc_q   <= opc_d;
      pb_q    <= pb_d;
      opa_q   <= opa_d;
      opb_q   <= opb_d;
      res_q   <= res_d;
      d_q     <= d_d;
      x_q     <= x_d;
      y_q     <= y_d;
      sp_q    <= sp_d;
      pc_q    <= pc_d;
      ext_q   <= ext_d;
      ea_q    <= ea_d;
      addr_q  <= addr_d;
      hnd_q   <= hnd_d;
      vaddr_q <= vaddr_d;
      src_q   <= src_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_neg_flag: // [RQ1]
    assert property (alu_go |=> flags_q[`OPD_F_N] == ($past(alu_wide) ? res_q[15] : res_q[7]))
      else $error("sign flag does not follow result");
  a_zero_flag: // [RQ2]
    assert property (alu_go |=> flags_q[`OPD_F_Z] == (res_q == 16'h0000))
      else $error("zero flag does not follow result");
  a_ovf_flag: // [RQ3]
    assert property (alu_go && !alu_sub && alu_wide && opa_q[15] == opb_q[15]
                     |=> flags_q[`OPD_F_V] == (res_q[15] != $past(opa_q[15])))
      else $error("overflow flag wrong on add");
  a_borrow_flag: // [RQ4]
    assert property (alu_go && alu_sub && alu_wide
                     |=> flags_q[`OPD_F_C] == ($past(opa_q) < $past(opb_q)))
      else $error("carry flag wrong on subtract");
  a_direct_page: // [RQ7]
    assert property (state_q == ST_EXT && mem_rsp.ack && mode_q == M_DIRECT_PAGE
                     |=> ea_q == {8'h00, $past(mem_rsp.data)} && state_q == ST_IDLE)
      else $error("direct address not in page zero");
  a_prefix_page: // [RQ16]
    assert property (state_q == ST_OPC && mem_rsp.ack && mem_rsp.data == `OPD_PFX && !page2_q
                     |=> page2_q && state_q == ST_OPC)
      else $error("prefix byte did not open second page");
  a_vec_window: // [RQ17]
    assert property (state_q == ST_VEC |-> mem_req.addr[15:7] == `OPD_VEC_WIN)
      else $error("vector read outside top bytes");
  a_vec_order: // [RQ25]
    assert property (state_q == ST_VEC && cnt_q && mem_rsp.ack
                     |=> state_q == ST_VEC && mem_req.addr == $past(mem_req.addr) + 16'h0001)
      else $error("vector low byte not at next address");
  a_por_first: // [RQ20]
    assert property (rst_n && state_q == ST_IDLE && por_q
                     |=> state_q == ST_VEC && vaddr_q == `OPD_VEC_TOP)
      else $error("reset vector not served first");
  a_nmi_mask: // [RQ21]
    assert property (state_q == ST_IDLE && flags_q[`OPD_F_X]
                     |=> !(state_q == ST_VEC && src_q == `OPD_SRC_NMI))
      else $error("nmi pin taken while masked");
  a_prio_lock: // [RQ24]
    assert property (wr_go && address == `OPD_A_PRIO && !flags_q[`OPD_F_I] |=> $stable(prio_q))
      else $error("promotion written with mask clear");

endmodule // opd_core

// *** opd_mem.sv ***
// Byte memory model that answers the decoder's fetches
`timescale 1ns/1ps
module opd_mem (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Memory port
  input  wire opd_pkg::opd_mreq_s mem_req,
  output opd_pkg::opd_mrsp_s      mem_rsp,
  // Gap counted down from each answer's ack cycle; delays the next answer by slow-1 cycles when slow is above 1
  input  wire logic [1:0]         slow
);
  import opd_pkg::*;
  logic [7:0] bytes [0:65535];
  logic [1:0] gap_q;
  // Every location, vectors included, holds a known byte pattern
  initial begin
    for (int a = 0; a < 65536; a++) begin
      bytes[a] = 8'(a[15:8] ^ a[7:0] ^ 8'h5a);
    end
  end
  // One byte per ack at the requested address; data toggles when idle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_rsp <= '0;
      gap_q   <= 2'h0;
    end else if (mem_req.rd && !mem_rsp.ack && gap_q == 2'h0) begin
      mem_rsp.ack  <= 1'b1;
      mem_rsp.data <= bytes[mem_req.addr];
      gap_q        <= slow;
    end else begin
      mem_rsp.ack  <= 1'b0;
      mem_rsp.data <= ~mem_rsp.data;
      if (gap_q != 2'h0) gap_q <= gap_q - 2'h1;
    end
  end
endmodule // opd_mem

// *** tb_top.sv ***
// Self-checking bench for the operand decoder
`timescale 1ns/1ps
`include "opd_params.svh"
module tb_top;
  import opd_pkg::*;
  logic        core_clk, rst_n, read, write, waitrequest;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, q, q2, t;
  logic [3:0]  byteenable;
  opd_mreq_s   mem_req;
  opd_mrsp_s   mem_rsp;
  logic [4:0]  exc;
  logic [7:0]  irq_req, pb, e1, e2, op;
  logic [1:0]  slow;
  logic [15:0] x_v, y_v, sp_v, d_v, pc, a, b;
  logic [47:0] w;
  int          miscompares, check_count, f, rr, s;
  opd_core uut (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .clkmon_reset(exc[0]), .watchdog_reset(exc[1]), .unimpl_trap(exc[2]),
    .soft_trap_instr(exc[3]), .pin_level_nmi_request(exc[4]), .irq_req(irq_req));
  opd_mem mem_i (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .slow(slow));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    test_done();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk);
    address   <= ad;
    writedata <= d;
    read      <= ~wr;
    write     <= wr;
    for (int n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (waitrequest === 1'b0) begin
        r = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int n = 0; n < 60; n++) begin
      bus(1'b0, `OPD_A_STAT, 32'h0, q);
      if ((q & m) === v) return;
    end
    hang();
  endtask
  task automatic dec(input logic [2:0] m, input logic [39:0] bs);
    for (int i = 0; i < 5; i++) mem_i.bytes[16'(pc + i)] = bs[39 - 8 * i -: 8];
    bus(1'b1, `OPD_A_SPPC, {pc, sp_v}, q);
    bus(1'b1, `OPD_A_CTRL, {25'h0, m, 4'h1}, q);
    poll(32'hf, 32'h0);
    bus(1'b0, `OPD_A_EA, 32'h0, q);
  endtask
  function automatic logic [15:0] vec_of(logic [15:0] v);
    return {mem_i.bytes[v], mem_i.bytes[16'(v + 16'h1)]};
  endfunction
  // Returns flags {n,z,v,c} above the result
  function automatic logic [19:0] alu(logic [15:0] x, logic [15:0] y, logic sb, logic wd);
    logic [16:0] r;
    logic [15:0] res;
    int k;
    k = wd ? 15 : 7;
    if (!wd) begin
      x[15:8] = 8'h0;
      y[15:8] = 8'h0;
    end
    r = sb ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    res = wd ? r[15:0] : {8'h0, r[7:0]};
    return {r[k], res == 16'h0, (x[k] ^ r[k]) & (sb ^ ~(x[k] ^ y[k])), r[k + 1], res};
  endfunction
  // Returns the updated base register above the effective address
  function automatic logic [31:0] ea_of(logic [7:0] p, logic [15:0] c, logic [7:0] e,
                                        logic [7:0] g);
    logic [15:0] rg [4];
    logic [15:0] bs, nw, ea;
    int k;
    k = (p[7:5] == 3'b111 && !p[2]) ? 1 + p[1] : 0;
    rg = '{x_v, y_v, sp_v, 16'(c + 2 + k)};
    bs = rg[p[7:6]];
    nw = bs;
    if (!p[5]) begin
      ea = bs + {{11{p[4]}}, p[4:0]};
    end else if (p[7:5] != 3'b111) begin
      nw = bs + (p[3] ? {12'hfff, p[3:0]} : {12'h0, p[3:0]} + 16'h1);
      ea = p[4] ? bs : nw;
    end else begin
      bs = rg[p[4:3]];
      case (p[2:0])
        3'h2, 3'h3: ea = bs + {e, g};
        3'h4: ea = bs + {8'h0, d_v[15:8]};
        3'h5: ea = bs + {8'h0, d_v[7:0]};
        3'h6, 3'h7: ea = bs + d_v;
        default: ea = bs + {{8{p[0]}}, e};
      endcase
      if (p[1:0] == 2'h3) ea = vec_of(ea);
    end
    return {nw, ea};
  endfunction
  initial begin
    s = $urandom(90517);
    {rst_n, read, write, exc, irq_req, slow} = '0;
    address    = 6'h0;
    writedata  = 32'h0;
    byteenable = 4'hf;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    poll(32'hf, 32'h0);
    bus(1'b0, `OPD_A_FLAG, 32'h0, q);
    chk(q[7:0], 8'h50);
    bus(1'b0, `OPD_A_SPPC, 32'h0, q);
    chk(q[31:16], vec_of(16'hfffe));
    bus(1'b0, 6'h3c, 32'h0, q);
    chk(q, 32'h0);
    // Corner cases first, then random operands
    for (int i = 0; i < 24; i++) begin
      a = 16'($urandom);
      b = 16'($urandom);
      f = $urandom;
      case (i)
        0: {a, b, f} = {16'h007f, 16'h0001, 32'h0};
        1: {a, b, f} = {16'h0020, 16'h0020, 32'h1};
        2: {a, b, f} = {16'h8000, 16'h0001, 32'h3};
        3: {a, b, f} = {16'hffff, 16'h0001, 32'h2};
        4: {a, b, f} = {16'h0010, 16'h0020, 32'h1};
        default: ;
      endcase
      bus(1'b1, `OPD_A_OPND, {b, a}, q);
      bus(1'b1, `OPD_A_CTRL, {28'h0, f[1], f[0], 2'b10}, q);
      t = 32'(alu(a, b, f[0], f[1]));
      bus(1'b0, `OPD_A_RES, 32'h0, q);
      chk(q[15:0], t[15:0]);
      bus(1'b0, `OPD_A_FLAG, 32'h0, q);
      chk(q[3:0], t[19:16]);
    end
    op = 8'h40 | 8'($urandom);
    e1 = 8'($urandom);
    e2 = 8'($urandom);
    pc = 16'h1001 | 16'($urandom_range(4095));
    dec(3'h2, {8'h18, op, e1, 16'h0});
    chk(q[23:0], {op, 8'h00, e1});
    bus(1'b0, `OPD_A_STAT, 32'h0, q);
    chk(q[4], 1'b1);
    dec(3'h3, {op, e1, e2, 16'h0});
    chk(q[23:0], {op, e1, e2});
    dec(3'h4, {op, e1, 24'h0});
    chk(q[15:0], 16'(pc + 2 + {{8{e1[7]}}, e1}));
    bus(1'b0, `OPD_A_STAT, 32'h0, q);
    chk(q[4], 1'b0);
    dec(3'h5, {op, e1, e2, 16'h0});
    chk(q[15:0], 16'(pc + 3 + {e1, e2}));
    // Every indexed form in turn with random registers and bytes
    for (int i = 0; i < 36; i++) begin
      f  = i % 9;
      rr = f == 8 ? $urandom_range(2) : $urandom_range(3);
      t  = $urandom;
      pb = {3'b111, 2'(rr), f == 1 ? {2'b00, t[0]} : 3'(f)};
      if (f == 0) pb = {2'(rr), 1'b0, t[4:0]};
      if (f == 8) pb = {2'(rr), 1'b1, t[4:0]};
      x_v  = 16'($urandom);
      y_v  = 16'($urandom);
      sp_v = 16'($urandom);
      d_v  = 16'($urandom);
      pc   = 16'h1000 | 16'($urandom_range(4095));
      slow <= 2'($urandom);
      e1 = 8'($urandom);
      e2 = 8'($urandom);
      bus(1'b1, `OPD_A_XY, {y_v, x_v}, q);
      bus(1'b1, `OPD_A_ACC, {16'h0, d_v}, q);
      dec(3'h6, {op, pb, e1, e2, 8'h0});
      t = ea_of(pb, pc, e1, e2);
      chk(q, {pb, op, t[15:0]});
      if (f == 8) begin
        bus(1'b0, `OPD_A_XY, 32'h0, q);
        bus(1'b0, `OPD_A_SPPC, 32'h0, q2);
        w = {q2[15:0], q};
        chk(16'(w >> (16 * rr)), t[31:16]);
      end
    end
    // All sources from one rank down raised together; the highest must win
    slow <= 2'h3;
    for (s = 1; s < 6; s++) begin
      bus(1'b1, `OPD_A_FLAG, 32'h10, q);
      exc <= 5'h1f << (s - 1);
      poll(32'h1f00, s << 8);
      exc <= 5'h0;
      poll(32'hf, 32'h0);
      bus(1'b0, `OPD_A_VEC, 32'h0, q);
      chk(q, {16'hfffe - 16'(2 * s), vec_of(16'hfffe - 16'(2 * s))});
    end
    bus(1'b1, `OPD_A_FLAG, 32'h50, q);
    bus(1'b1, `OPD_A_SPPC, 32'h12340000, q);
    exc     <= 5'h10;
    irq_req <= 8'h09;
    repeat (20) @(posedge core_clk);
    bus(1'b0, `OPD_A_STAT, 32'h0, q);
    chk(q[12:8], 5'h05);
    // A masked request must not load a handler into the program counter
    bus(1'b0, `OPD_A_SPPC, 32'h0, q);
    chk(q[31:16], 16'h1234);
    exc <= 5'h0;
    bus(1'b1, `OPD_A_PRIO, 32'hec, q);
    bus(1'b0, `OPD_A_PRIO, 32'h0, q);
    chk(q[7:0], 8'hec);
    bus(1'b1, `OPD_A_FLAG, 32'h40, q);
    poll(32'h1f00, 32'h900);
    irq_req <= 8'h0;
    poll(32'hf, 32'h0);
    bus(1'b0, `OPD_A_VEC, 32'h0, q);
    chk(q, {16'hffec, vec_of(16'hffec)});
    bus(1'b1, `OPD_A_FLAG, 32'h40, q);
    bus(1'b1, `OPD_A_PRIO, 32'hf2, q);
    bus(1'b0, `OPD_A_PRIO, 32'h0, q);
    chk(q[7:0], 8'hec);
    test_done();
  end
endmodule // tb_top
